// ===== rtl/uecs_defs.vh
`ifndef UECS_DEFS_VH
`define UECS_DEFS_VH

// event codes
`define UECS_EV_PRIO_UPDATE 8'h31
`define UECS_EV_DRAM_RETRY 8'h32
`define UECS_EV_FRC_ACK 8'h33
`define UECS_EV_SLEEP 8'h34

// unit mask bit positions
`define UECS_UM_CH0 0
`define UECS_UM_CH1 1
`define UECS_UM_CH2 2
`define UECS_UM_HUB 0
`define UECS_UM_REMOTE 1
`define UECS_UM_LOCAL 2
`define UECS_UM_HUB_CLASH 3
`define UECS_UM_REMOTE_CLASH 4
`define UECS_UM_LOCAL_CLASH 5

// all-sources masks
`define UECS_UM_ANY3 8'h07

// widths and reset values
`define UECS_CNT_W 48
`define UECS_CNT_RST 48'h000000000000
`define UECS_SUB_W 8

`endif

// ===== rtl/uecs_sleep_gate.v
`include "uecs_defs.vh"

// per-request sleep flags: a sleeping request may not be scheduled to the memory controller
module uecs_sleep_gate (
	input wire mclk, // core clock
	input wire rst_n, // async reset, active low
	input wire [7:0] slot_sleep_set, // put slot to sleep (pulse per slot)
	input wire [7:0] slot_wake, // release slot (pulse per slot)
	input wire [7:0] slot_sched_req, // slot asks to be scheduled
	output wire [7:0] slot_sched_ok, // slot scheduling granted
	output wire [7:0] slot_asleep_q // current sleep flags
);
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_slot
			reg asleep_q;
			// set wins over a wake in the same cycle
			always @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					asleep_q <= 1'h0;
				end else if (slot_sleep_set[i]) begin
					asleep_q <= 1'h1;
				end else if (slot_wake[i]) begin
					asleep_q <= 1'h0;
				end
			end
			assign slot_asleep_q[i] = asleep_q;
			// a slot entering sleep this cycle is already barred
			assign slot_sched_ok[i] = slot_sched_req[i] & ~asleep_q & ~slot_sleep_set[i];
		end
	endgenerate
endmodule

// ===== rtl/uecs_top.v
// Notes on behaviour
// - code 31h with mask 07h counts priority updates sent to any of the three channels.
// - a high or critical isochronous request that matches an already issued normal request on channel 0, 1 or 2 raises a priority update.
// - code 32h counts dram retries with mask bits 01h, 02h, 04h for channels 0, 1 and 2.
// - code 32h with mask 07h counts dram retries from any channel.
// - retries only occur in reliability mode, so retry events are gated off otherwise.
// - code 33h counts forced ack conflict messages to hub 01h, remote home 02h, local home 04h, all 07h.
// - code 34h counts ordering sleeps from hub 01h, remote 02h and local 04h sources.
// - code 34h counts address clash sleeps from hub 08h, remote 10h and local 20h sources.
// - a sleeping request is never scheduled to the memory controller.
`include "uecs_defs.vh"

module uecs_top (
	input wire mclk, // core clock, 125 mhz
	input wire rst_n, // async reset, active low
	input wire [7:0] evt_code, // selected event code
	input wire [7:0] unit_mask, // selected unit mask
	input wire cnt_enable, // counting enabled
	input wire cnt_clear, // clear counter (pulse)
	input wire reliability_mode, // dram controller in reliability mode
	input wire isochronous_request, // high or critical isochronous request arrives
	input wire normal_match_issued, // matching normal request already issued
	input wire [1:0] match_channel, // channel of the matching request
	input wire [2:0] dram_retry_ch, // raw retry per channel
	input wire [2:0] forced_ack_conflict, // forced ack conflict sent: hub, remote, local
	input wire [2:0] sleep_order, // ordering sleep: hub, remote, local
	input wire [2:0] sleep_clash, // address clash sleep: hub, remote, local
	input wire [7:0] slot_sleep_set, // per slot sleep entry
	input wire [7:0] slot_wake, // per slot wake
	input wire [7:0] slot_sched_req, // per slot schedule request
	output wire [7:0] slot_sched_ok, // per slot schedule grant
	output wire [7:0] slot_asleep, // per slot sleep state
	output reg [2:0] priority_update_q, // priority update sent per channel
	output reg [`UECS_CNT_W-1:0] event_count_q, // event counter
	output reg count_pulse_q // counter incremented last cycle
);
	reg [`UECS_SUB_W-1:0] sub_d;
	reg [`UECS_SUB_W-1:0] sub_prio;
	reg [`UECS_SUB_W-1:0] sub_retry;
	reg [`UECS_SUB_W-1:0] sub_ack;
	reg [`UECS_SUB_W-1:0] sub_sleep;
	reg [2:0] chan_sel_d;
	reg sel_prio_d;
	reg sel_retry_d;
	reg sel_ack_d;
	reg sel_sleep_d;
	reg hit_d;
	reg pulse_d;
	reg [`UECS_CNT_W-1:0] count_d;
	wire upd_cause;
	wire [2:0] upd_d;
	wire [2:0] retry_gated;
	wire [`UECS_SUB_W-1:0] masked;
	genvar g;

	// an update needs the urgent request and an already issued normal twin
	assign upd_cause = isochronous_request & normal_match_issued;

	// channel of the twin request; the fourth code names no channel
	always @* begin
		chan_sel_d = 3'h0;
		case (match_channel)
			2'h0: begin
				chan_sel_d = 3'h1;
			end
			2'h1: begin
				chan_sel_d = 3'h2;
			end
			2'h2: begin
				chan_sel_d = 3'h4;
			end
			default: begin
				chan_sel_d = 3'h0;
			end
		endcase
	end

	generate
		for (g = 0; g < 3; g = g + 1) begin : g_upd
			assign upd_d[g] = upd_cause & chan_sel_d[g];
		end
	endgenerate

	// the update leaves one cycle after its cause, so code 31h counts one edge later
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			priority_update_q <= 3'h0;
		end else begin
			priority_update_q <= upd_d;
		end
	end

	// retries only exist in reliability mode; anything else is noise
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_retry
			assign retry_gated[g] = dram_retry_ch[g] & reliability_mode;
		end
	endgenerate

	// event code decode, one select per family
	always @* begin
		sel_prio_d = 1'h0;
		sel_retry_d = 1'h0;
		sel_ack_d = 1'h0;
		sel_sleep_d = 1'h0;
		case (evt_code)
			`UECS_EV_PRIO_UPDATE: begin
				sel_prio_d = 1'h1;
			end
			`UECS_EV_DRAM_RETRY: begin
				sel_retry_d = 1'h1;
			end
			`UECS_EV_FRC_ACK: begin
				sel_ack_d = 1'h1;
			end
			`UECS_EV_SLEEP: begin
				sel_sleep_d = 1'h1;
			end
			default: begin
				sel_prio_d = 1'h0;
			end
		endcase
	end

	// priority updates by channel
	always @* begin
		sub_prio = 8'h00;
		sub_prio[`UECS_UM_CH0] = priority_update_q[0];
		sub_prio[`UECS_UM_CH1] = priority_update_q[1];
		sub_prio[`UECS_UM_CH2] = priority_update_q[2];
	end

	// retries by channel, already gated by reliability mode
	always @* begin
		sub_retry = 8'h00;
		sub_retry[`UECS_UM_CH0] = retry_gated[0];
		sub_retry[`UECS_UM_CH1] = retry_gated[1];
		sub_retry[`UECS_UM_CH2] = retry_gated[2];
	end

	// forced ack conflicts by destination
	always @* begin
		sub_ack = 8'h00;
		sub_ack[`UECS_UM_HUB] = forced_ack_conflict[0];
		sub_ack[`UECS_UM_REMOTE] = forced_ack_conflict[1];
		sub_ack[`UECS_UM_LOCAL] = forced_ack_conflict[2];
	end

	// sleeps by source: ordering in bits 0 to 2, address clashes in bits 3 to 5
	always @* begin
		sub_sleep = 8'h00;
		sub_sleep[`UECS_UM_HUB] = sleep_order[0];
		sub_sleep[`UECS_UM_REMOTE] = sleep_order[1];
		sub_sleep[`UECS_UM_LOCAL] = sleep_order[2];
		sub_sleep[`UECS_UM_HUB_CLASH] = sleep_clash[0];
		sub_sleep[`UECS_UM_REMOTE_CLASH] = sleep_clash[1];
		sub_sleep[`UECS_UM_LOCAL_CLASH] = sleep_clash[2];
	end

	// unknown codes select no family and count nothing
	always @* begin
		sub_d = 8'h00;
		case ({sel_sleep_d, sel_ack_d, sel_retry_d, sel_prio_d})
			4'h1: begin
				sub_d = sub_prio;
			end
			4'h2: begin
				sub_d = sub_retry;
			end
			4'h4: begin
				sub_d = sub_ack;
			end
			4'h8: begin
				sub_d = sub_sleep;
			end
			default: begin
				sub_d = 8'h00;
			end
		endcase
	end

	// each sub-event passes only where its mask bit is set
	generate
		for (g = 0; g < `UECS_SUB_W; g = g + 1) begin : g_mask
			assign masked[g] = sub_d[g] & unit_mask[g];
		end
	endgenerate

	// several selected sub-events in one cycle still add only one
	always @* begin
		hit_d = cnt_enable & (|masked);
	end

	// clear wins over an increment that falls in the same cycle
	always @* begin
		count_d = event_count_q;
		pulse_d = 1'h0;
		if (cnt_clear) begin
			count_d = `UECS_CNT_RST;
		end else if (hit_d) begin
			count_d = event_count_q + {{(`UECS_CNT_W-1){1'h0}}, 1'h1};
			pulse_d = 1'h1;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			event_count_q <= `UECS_CNT_RST;
			count_pulse_q <= 1'h0;
		end else begin
			event_count_q <= count_d;
			count_pulse_q <= pulse_d;
		end
	end

	uecs_sleep_gate u_sleep (
		.mclk(mclk),
		.rst_n(rst_n),
		.slot_sleep_set(slot_sleep_set),
		.slot_wake(slot_wake),
		.slot_sched_req(slot_sched_req),
		.slot_sched_ok(slot_sched_ok),
		.slot_asleep_q(slot_asleep)
	);
endmodule

// ===== testbench/uecs_props.sv
module uecs_props (
	input wire mclk, // core clock
	input wire rst_n, // async reset, active low
	input wire cnt_enable, // counting enabled
	input wire cnt_clear, // counter clear
	input wire reliability_mode, // retries allowed
	input wire isochronous_request, // urgent request
	input wire normal_match_issued, // twin already issued
	input wire count_pulse_q, // increment seen
	input wire [1:0] match_channel, // twin channel
	input wire [7:0] evt_code, // selected code
	input wire [7:0] unit_mask, // selected mask
	input wire [7:0] slot_sched_ok, // slot grants
	input wire [7:0] slot_asleep, // slot sleep flags
	input wire [2:0] dram_retry_ch, // retries per channel
	input wire [2:0] forced_ack_conflict, // forced ack per destination
	input wire [2:0] sleep_order, // ordering sleeps
	input wire [2:0] sleep_clash, // address clash sleeps
	input wire [2:0] priority_update_q, // updates per channel
	input wire [47:0] event_count_q // counter
);
	timeunit 1ns / 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire go = cnt_enable & !cnt_clear;
	property p_iso; !isochronous_request |=> !priority_update_q; endproperty
	a_iso: assert property (p_iso) else $error("stray update");
	property p_upd; evt_code==8'h31 && go && priority_update_q & unit_mask |=> count_pulse_q; endproperty
	a_upd: assert property (p_upd) else $error("miss");
	property p_ret; evt_code==8'h32 && go && reliability_mode && dram_retry_ch & unit_mask |=> count_pulse_q; endproperty
	a_ret: assert property (p_ret) else $error("miss");
	property p_ras; evt_code==8'h32 && !reliability_mode |=> !count_pulse_q; endproperty
	a_ras: assert property (p_ras) else $error("stray");
	property p_ack; evt_code==8'h33 && go && forced_ack_conflict & unit_mask |=> count_pulse_q; endproperty
	a_ack: assert property (p_ack) else $error("miss");
	property p_slp; evt_code==8'h34 && go && {sleep_clash, sleep_order} & unit_mask |=> count_pulse_q; endproperty
	a_slp: assert property (p_slp) else $error("miss");
	property p_gate; !(slot_sched_ok & slot_asleep); endproperty
	a_gate: assert property (p_gate) else $error("grant");
	property p_one; count_pulse_q |-> event_count_q == $past(event_count_q) + 1; endproperty
	a_one: assert property (p_one) else $error("step");
	property p_cause; isochronous_request && normal_match_issued |=> priority_update_q == (3'h1 << $past(match_channel)); endproperty
	a_cause: assert property (p_cause) else $error("update channel");
	property p_clr; cnt_clear |=> event_count_q == 48'h0 && !count_pulse_q; endproperty
	a_clr: assert property (p_clr) else $error("clear");
endmodule
bind uecs_top uecs_props u_props (.*);

// ===== testbench/tb_top.sv
module tb_top;
	timeunit 1ns / 1ps;
	logic mclk = 0, rst_n = 0, cnt_clear = 0, cnt_enable = 1, reliability_mode = 1, normal_match_issued = 1;
	logic isochronous_request, count_pulse_q;
	logic [1:0] match_channel;
	logic [2:0] dram_retry_ch, forced_ack_conflict, sleep_order, sleep_clash, priority_update_q;
	logic [7:0] evt_code, unit_mask, slot_sleep_set = 8'h05, slot_wake = 0, slot_sched_req = 8'hff, slot_sched_ok;
	logic [7:0] slot_asleep;
	logic [47:0] event_count_q, b;
	logic [30:0] ev = 0;
	int num_errors, checked;
	assign {evt_code, unit_mask, isochronous_request, match_channel, dram_retry_ch, forced_ack_conflict, sleep_clash,
		sleep_order} = ev;
	uecs_top u_dut (.*);
	initial forever #4 mclk = ~mclk;
	task automatic chk(string n, logic [47:0] e, g);
		checked++;
		num_errors += int'(g !== e);
		if (g !== e) $display("ERROR %s exp %h got %h", n, e, g);
	endtask
	// one event burst; the extra cycle covers the two-edge lag of priority updates
	task automatic hit(logic [30:0] s, logic e);
		@(negedge mclk);
		b = event_count_q;
		ev = s;
		@(negedge mclk);
		ev[14:0] = 0;
		@(negedge mclk);
		chk("count", b + e, event_count_q);
	endtask
	task automatic s_chan;
		for (int n = 0; n < 36; n++)
			hit({8'h31+8'(n/12), n%4==3 ? 8'h07 : 8'h01<<n%4, n<12, 2'(n/4%3),
				12'h1<<12-3*(n/12)+n/4%3}, n%4==3 || n%4==n/4%3);
		hit({16'h3307, 15'h01c0}, 1);
		hit({16'h3107, 15'h7000}, 0);
		hit({16'h35ff, 15'h0fff}, 0);
		reliability_mode = 0;
		hit({16'h3207, 15'h0e00}, 0);
	endtask
	task automatic s_ctl;
		normal_match_issued = 0;
		hit({16'h3107, 15'h4000}, 0);
		normal_match_issued = 1;
		cnt_enable = 0;
		hit({16'h3307, 15'h01c0}, 0);
		cnt_enable = 1;
		@(negedge mclk);
		ev = {16'h3104, 15'h6000};
		@(negedge mclk);
		chk("update", 48'h4, 48'(priority_update_q));
		ev[14:0] = 0;
		cnt_clear = 1;
		@(negedge mclk);
		cnt_clear = 0;
		chk("count", 48'h0, event_count_q);
	endtask
	task automatic s_sleep;
		for (int i = 0; i < 36; i++)
			hit({8'h34, 8'h01<<i%6, 9'h0, 6'h1<<i/6}, i%6==i/6);
	endtask
	task automatic s_gate;
		chk("grant", 48'hfa, 48'(slot_sched_ok));
		chk("asleep", 48'h05, 48'(slot_asleep));
		slot_sleep_set = 0;
		slot_wake = 8'h03;
		#1 chk("grant", 48'hfa, 48'(slot_sched_ok));
		@(negedge mclk);
		slot_wake = 0;
		chk("grant", 48'hfb, 48'(slot_sched_ok));
		chk("asleep", 48'h04, 48'(slot_asleep));
		slot_sleep_set = 8'h10;
		slot_wake = 8'h10;
		@(negedge mclk);
		slot_sleep_set = 0;
		slot_wake = 0;
		chk("asleep", 48'h14, 48'(slot_asleep));
	endtask
	task automatic tally_and_finish;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge mclk);
		rst_n = 1;
		s_chan();
		s_ctl();
		s_sleep();
		s_gate();
		tally_and_finish();
	end
	initial begin
		#5000;
		num_errors++;
		tally_and_finish();
	end
endmodule
